// File: src/regulator_fault_supervisor_pkg.sv
// Constants, types and carriers for the regulator fault supervisor
package regulator_fault_supervisor_pkg;
	// Clock
	localparam int CLK_HZ = 10_000_000;
	localparam int CYC_PER_US = CLK_HZ / 1_000_000;
	// Timing
	localparam int SAMPLE_US = 132;
	localparam int SAMPLE_CYC = SAMPLE_US * CYC_PER_US;
	localparam int OC_WAIT_MS = 8;
	localparam int OC_WAIT_CYC = OC_WAIT_MS * 1000 * CYC_PER_US;
	localparam int SS_DELAY_US = 4600;
	localparam int SS_DELAY_CYC = SS_DELAY_US * CYC_PER_US;
	localparam int CNT_W = 20;
	localparam int SMP_W = 11;
	// Voltage levels in millivolts
	localparam logic [11:0] LOAD_CURRENT_MONITOR_PIN_FS_MV = 12'h384;
	localparam logic [11:0] LOAD_CURRENT_MONITOR_PIN_OC_MV = 12'h460;
	localparam logic [12:0] OV_FIXED_MV = 13'h08FC;
	localparam logic [12:0] OV_TRACK_MV = 13'h00B3;
	localparam logic [12:0] OV_RELEASE_MV = 13'h006B;
	// Linear code scale: 255/900 = 17/60
	localparam logic [15:0] CODE_NUM = 16'h0011;
	localparam logic [15:0] CODE_DEN = 16'h003C;
	localparam logic [7:0] CODE_MAX = 8'hFF;
	// Register map
	localparam logic [7:0] ADDR_CURRENT = 8'h15;
	localparam logic [7:0] ADDR_CFG_MAIN = 8'h30;
	localparam logic [7:0] ADDR_CFG_AUX = 8'h31;
	localparam logic [1:0] CFG_RESET = 2'h2;
	// Rails and phases
	localparam int RAILS = 2;
	localparam int PHASES = 7;
	localparam int MAIN_PHASES = 6;
	// Thermal thresholds in 0.01 % of supply, settings 90..120 degrees
	localparam logic [2:0] TLIM_LAST = 3'h6;
	localparam logic [13:0] HOT_SET [7] = '{14'h11C8, 14'h1082, 14'h0F48, 14'h0E1E,
		14'h0D04, 14'h0BFC, 14'h0B08};
	localparam logic [13:0] HOT_CLR [7] = '{14'h1294, 14'h1144, 14'h1002, 14'h0ED0,
		14'h0DAC, 14'h0C98, 14'h0B9A};

	typedef enum logic [5:0] {
		ST_OFF = 6'h01,
		ST_DELAY = 6'h02,
		ST_SOFT = 6'h04,
		ST_RUN = 6'h08,
		ST_OC_WAIT = 6'h10,
		ST_OV_LATCH = 6'h20
	} rail_state_e;

	typedef struct packed {
		logic [10:0] load_current_monitor_pin_mv;
		logic [RAILS-1:0][11:0] vout_mv;
		logic [RAILS-1:0][11:0] dac_mv;
		logic por_ok;
		logic pwr_en;
		logic vtt_en;
		logic [RAILS-1:0] vid_off;
		logic [RAILS-1:0] ss_done;
		logic [RAILS-1:0] avg_over;
		logic [PHASES-1:0] peak_over;
		logic [PHASES-1:0] cycle_start;
		logic [PHASES-1:0] pwm_req;
		logic [13:0] tm_ratio;
		logic [13:0] tms_ratio;
		logic [2:0] tlimit;
	} pins_s;
endpackage : regulator_fault_supervisor_pkg

// File: src/regulator_fault_supervisor.sv
// Fault supervisor: current report, ready, OV/OC protection, thermal flag
//
// What this block does
// R1 - Sample monitor voltage every 132us, convert linearly into 8-bit current code.
// R2 - At or above 900mV code saturates at FFh and alert is pulled low.
// R3 - Monitor voltage above 1.12V starts an overcurrent shutdown.
// R4 - Ready held low in shutdown, released only after soft-start completes.
// R5 - Ready low on OC/OV fault, disable by either enable, POR or off code.
// R6 - Shared config one keeps ready high on zero code after first soft-start.
// R7 - Shared config resets 0 for main, 1 for aux; readies independent.
// R8 - OV detection active after POR even disabled; fixed 2.3V until soft-start.
// R9 - After soft-start the OV threshold tracks reference plus 179mV.
// R10 - On overvoltage every PWM output of that rail is driven low at once.
// R11 - PWM goes high impedance below reference plus 107mV, low again on recurrence.
// R12 - After OV the rail stops PWM, ready low until POR or enable cycling.
// R13 - Phase peak over limit blanks that PWM for rest of cycle, never shuts down.
// R14 - Average current over reference triggers overcurrent shutdown.
// R15 - Overcurrent shutdown puts PWM in high impedance for 8ms.
// R16 - After the wait, retry soft-start if enabled; repeat indefinitely.
// R17 - Thermal-hot flag only valid while the controller is enabled.
// R18 - Hot asserts when either input below set ratio, clears when both above release.
// R19 - Seven limit settings 90..120 degrees select assert and release ratios.
// R20 - Current code reads zero until first conversion; reads return latest result.
`timescale 1ns/1ns
module regulator_fault_supervisor
	import regulator_fault_supervisor_pkg::*;
#(
	parameter int OC_WAIT_CYCLES = OC_WAIT_CYC,
	parameter int SS_DELAY_CYCLES = SS_DELAY_CYC
) (
	// Clock and reset
	input wire logic clk_sys_i,
	input wire logic arst_n_i,
	// Pins and analog comparator results
	input wire pins_s pins_i,
	// Register access from the serial voltage-ID logic
	input wire logic reg_rd_i,
	input wire logic reg_wr_i,
	input wire logic [7:0] reg_addr_i,
	input wire logic [7:0] reg_wdata_i,
	output logic [7:0] reg_rdata_o,
	// PWM pins, three-state
	output logic [PHASES-1:0] pwm_o,
	output logic [PHASES-1:0] pwm_oe_n_o,
	// Open-drain pins, low enable pulls low
	output logic [RAILS-1:0] rail_ready_oe_n_o,
	output logic alert_oe_n_o,
	output logic thermal_hot_oe_n_o
);
	pins_s meta_r;
	pins_s pin_r;
	logic [SMP_W-1:0] smp_cnt_r;
	logic [7:0] code_r;
	logic [RAILS-1:0] cfg_r;
	logic en_prev_r;
	logic hot_r;
	logic [PHASES-1:0] limit_r;
	rail_state_e st_r [RAILS];
	logic [CNT_W-1:0] cnt_r [RAILS];
	logic [RAILS-1:0] first_done_r;
	logic [RAILS-1:0] ov_pull_r;

	// Two-stage input synchroniser
	always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			meta_r <= '0;
			pin_r <= '0;
		end else begin
			meta_r <= pins_i;
			pin_r <= meta_r;
		end
	end

	wire ctl_en = pin_r.por_ok & pin_r.pwr_en & pin_r.vtt_en;
	wire en_rise = ctl_en & ~en_prev_r;

	// Current conversion
	wire smp_tick = (smp_cnt_r == SMP_W'(SAMPLE_CYC - 1));
	wire [15:0] load_current_monitor_pin_scaled = {5'h00, pin_r.load_current_monitor_pin_mv} * CODE_NUM;
	wire load_current_monitor_pin_fs = {1'b0, pin_r.load_current_monitor_pin_mv} >= LOAD_CURRENT_MONITOR_PIN_FS_MV;
	wire load_current_monitor_pin_oc = {1'b0, pin_r.load_current_monitor_pin_mv} > LOAD_CURRENT_MONITOR_PIN_OC_MV; // R3
	wire [15:0] code_div = load_current_monitor_pin_scaled / CODE_DEN;
	wire [7:0] code_nxt = load_current_monitor_pin_fs ? CODE_MAX : code_div[7:0]; // R1 R2

	always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			smp_cnt_r <= '0;
			code_r <= '0; // R20
			alert_oe_n_o <= 1'b1;
		end else begin
			smp_cnt_r <= smp_tick ? '0 : smp_cnt_r + 1'b1;
			if (smp_tick) begin
				code_r <= code_nxt; // R1
				alert_oe_n_o <= ~load_current_monitor_pin_fs; // R2
			end
		end
	end

	// Register port
	wire wr_main = reg_wr_i & (reg_addr_i == ADDR_CFG_MAIN);
	wire wr_aux = reg_wr_i & (reg_addr_i == ADDR_CFG_AUX);
	wire [7:0] rd_mux = (reg_addr_i == ADDR_CURRENT) ? code_r : // R20
		(reg_addr_i == ADDR_CFG_MAIN) ? {7'h00, cfg_r[0]} :
		(reg_addr_i == ADDR_CFG_AUX) ? {7'h00, cfg_r[1]} : 8'h00;

	always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			cfg_r <= CFG_RESET; // R7
			reg_rdata_o <= '0;
			en_prev_r <= 1'b0;
		end else begin
			if (wr_main)
				cfg_r[0] <= reg_wdata_i[0];
			if (wr_aux)
				cfg_r[1] <= reg_wdata_i[0];
			if (reg_rd_i)
				reg_rdata_o <= rd_mux;
			en_prev_r <= ctl_en;
		end
	end

	// Per-rail supervision
	logic [RAILS-1:0] rail_drive;
	logic [RAILS-1:0] rail_pull;
	for (genvar r = 0; r < RAILS; r++) begin : g_rail
		wire [12:0] vout = {1'b0, pin_r.vout_mv[r]};
		wire [12:0] dac = {1'b0, pin_r.dac_mv[r]};
		wire early = (st_r[r] == ST_OFF) || (st_r[r] == ST_DELAY) || (st_r[r] == ST_SOFT);
		wire [12:0] ov_thr = early ? OV_FIXED_MV : dac + OV_TRACK_MV; // R8 R9
		wire ov_trip = vout > ov_thr;
		wire ov_below = vout < (dac + OV_RELEASE_MV);
		wire oc_trip = pin_r.avg_over[r] | ((r == 0) & load_current_monitor_pin_oc); // R3 R14
		wire vid_dis = pin_r.vid_off[r] & ~(cfg_r[r] & first_done_r[r]); // R6
		wire latched = st_r[r] == ST_OV_LATCH;
		wire cnt_end_wait = cnt_r[r] >= CNT_W'(OC_WAIT_CYCLES - 1);
		wire cnt_end_dly = cnt_r[r] >= CNT_W'(SS_DELAY_CYCLES - 1);
		rail_state_e st_nxt;

		always_comb begin
			st_nxt = st_r[r];
			case (st_r[r])
				ST_OFF: if (!vid_dis) st_nxt = ST_DELAY;
				ST_DELAY: if (cnt_end_dly) st_nxt = ST_SOFT;
				ST_SOFT: if (pin_r.ss_done[r]) st_nxt = ST_RUN;
				ST_RUN: if (vid_dis) st_nxt = ST_OFF; // R5
				ST_OC_WAIT: if (cnt_end_wait) st_nxt = ST_DELAY; // R16
				ST_OV_LATCH: st_nxt = ST_OV_LATCH; // R12
				default: st_nxt = ST_OFF;
			endcase
			if ((st_r[r] == ST_DELAY || st_r[r] == ST_SOFT || st_r[r] == ST_RUN) && oc_trip)
				st_nxt = ST_OC_WAIT; // R14 R15
			if (ov_trip)
				st_nxt = ST_OV_LATCH; // R10 R12
			if (!ctl_en && !latched && !ov_trip)
				st_nxt = ST_OFF; // R5
			if (en_rise)
				st_nxt = ST_OFF; // R12
		end

		always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
			if (!arst_n_i) begin
				st_r[r] <= ST_OFF;
				cnt_r[r] <= '0;
				first_done_r[r] <= 1'b0;
				ov_pull_r[r] <= 1'b0;
			end else begin
				st_r[r] <= st_nxt;
				cnt_r[r] <= (st_nxt != st_r[r]) ? '0 : cnt_r[r] + 1'b1;
				if (!ctl_en)
					first_done_r[r] <= 1'b0;
				else if (st_r[r] == ST_SOFT && st_nxt == ST_RUN)
					first_done_r[r] <= 1'b1;
				ov_pull_r[r] <= ov_trip | (ov_pull_r[r] & ~ov_below); // R10 R11
			end
		end

		assign rail_pull[r] = ov_pull_r[r] | ov_trip; // R10
		assign rail_drive[r] = ((st_r[r] == ST_SOFT) || (st_r[r] == ST_RUN)) && ctl_en; // R15
	end

	// Per-phase limiting and pin drive
	for (genvar p = 0; p < PHASES; p++) begin : g_phase
		localparam int RAIL = (p < MAIN_PHASES) ? 0 : 1;
		wire drv = rail_drive[RAIL] & ~rail_pull[RAIL];
		always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
			if (!arst_n_i) begin
				limit_r[p] <= 1'b0;
				pwm_o[p] <= 1'b0;
				pwm_oe_n_o[p] <= 1'b1;
			end else begin
				limit_r[p] <= pin_r.peak_over[p] | (limit_r[p] & ~pin_r.cycle_start[p]); // R13
				pwm_o[p] <= drv & pin_r.pwm_req[p] & ~limit_r[p] & ~pin_r.peak_over[p]; // R13
				pwm_oe_n_o[p] <= ~(rail_pull[RAIL] | drv); // R10 R11 R15
			end
		end
	end

	// Ready outputs, one per rail
	for (genvar r = 0; r < RAILS; r++) begin : g_ready
		always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
			if (!arst_n_i)
				rail_ready_oe_n_o[r] <= 1'b0;
			else
				rail_ready_oe_n_o[r] <= (st_r[r] == ST_RUN) & first_done_r[r] & ctl_en; // R4 R5 R7
		end
	end

	// Thermal flag with hysteresis
	wire [2:0] tsel = (pin_r.tlimit > TLIM_LAST) ? TLIM_LAST : pin_r.tlimit; // R19
	wire hot_set = (pin_r.tm_ratio < HOT_SET[tsel]) | (pin_r.tms_ratio < HOT_SET[tsel]); // R18
	wire hot_clr = (pin_r.tm_ratio > HOT_CLR[tsel]) & (pin_r.tms_ratio > HOT_CLR[tsel]); // R18
	wire hot_nxt = ctl_en & (hot_set | (hot_r & ~hot_clr)); // R17

	always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			hot_r <= 1'b0;
			thermal_hot_oe_n_o <= 1'b1;
		end else begin
			hot_r <= hot_nxt;
			thermal_hot_oe_n_o <= ~hot_nxt;
		end
	end
endmodule : regulator_fault_supervisor

// File: sim/gate_driver_model.sv
// Gate driver and pulled-up line model
`timescale 1ns/1ns
module gate_driver_model
	import regulator_fault_supervisor_pkg::*;
(
	// From supervisor
	input wire logic [PHASES-1:0] pwm_i,
	input wire logic [PHASES-1:0] pwm_oe_n_i,
	input wire logic [RAILS-1:0] ready_oe_n_i,
	input wire logic alert_oe_n_i,
	input wire logic hot_oe_n_i,
	// Line levels
	output logic [PHASES-1:0] gate_on_o,
	output logic [RAILS-1:0] ready_o,
	output logic alert_o,
	output logic hot_o
);
	// Released pwm keeps both switches off
	assign gate_on_o = pwm_i & ~pwm_oe_n_i;
	assign ready_o = ready_oe_n_i;
	assign alert_o = alert_oe_n_i;
	assign hot_o = hot_oe_n_i;
endmodule : gate_driver_model

// File: sim/regulator_fault_supervisor_asserts.sv
// Port checks for the regulator fault supervisor
`timescale 1ns/1ns
module regulator_fault_supervisor_asserts
	import regulator_fault_supervisor_pkg::*;
(
	// Clock
	input wire logic clk_sys_i,
	input wire logic arst_n_i,
	// Inputs
	input wire pins_s pins_i,
	input wire logic reg_rd_i,
	input wire logic reg_wr_i,
	input wire logic [7:0] reg_addr_i,
	input wire logic [7:0] reg_wdata_i,
	// Outputs
	input wire logic [7:0] reg_rdata_o,
	input wire logic [PHASES-1:0] pwm_o,
	input wire logic [PHASES-1:0] pwm_oe_n_o,
	input wire logic [RAILS-1:0] rail_ready_oe_n_o,
	input wire logic alert_oe_n_o,
	input wire logic thermal_hot_oe_n_o
);
	default clocking cb @(posedge clk_sys_i);
	endclocking
	default disable iff (!arst_n_i);
	wire logic en = pins_i.por_ok & pins_i.pwr_en & pins_i.vtt_en;
	AST_OFF_LOW: assert property (!en [*5] |-> rail_ready_oe_n_o == 2'h0)
		else $error("ready while disabled");
	AST_OV_LOW: assert property ((pins_i.vout_mv[0] > 12'h8FC &&
		pins_i.vout_mv[0] > pins_i.dac_mv[0] + 12'h0B3) [*5] |-> {pwm_oe_n_o[5:0], pwm_o[0]} == 7'h00)
		else $error("pwm not pulled low");
	AST_OC_HIZ: assert property ((pins_i.avg_over[0] &&
		pins_i.vout_mv[0] < pins_i.dac_mv[0] + 12'h06B) [*5] |-> pwm_oe_n_o[5:0] == 6'h3F)
		else $error("pwm driven in shutdown");
	AST_RDY_SS: assert property ($rose(rail_ready_oe_n_o[0]) |->
		$past(pins_i.ss_done[0], 3) && $past(en, 3)) else $error("early ready");
	AST_ALERT: assert property ($changed(alert_oe_n_o) |->
		alert_oe_n_o == ($past(pins_i.load_current_monitor_pin_mv, 3) < 11'h384)) else $error("alert level");
	AST_HOT_SET: assert property ((en && pins_i.tlimit == 3'h2 &&
		pins_i.tm_ratio < 14'h0F48) [*5] |-> !thermal_hot_oe_n_o) else $error("hot missing");
	AST_HOT_EN: assert property (!en [*5] |-> thermal_hot_oe_n_o)
		else $error("hot while disabled");
	AST_PEAK: assert property (pins_i.peak_over[6] |-> ##3 !pwm_o[6])
		else $error("peak not blanked");
endmodule : regulator_fault_supervisor_asserts
bind regulator_fault_supervisor regulator_fault_supervisor_asserts u_chk (.*);

// File: sim/tb_top.sv
// Self-checking bench for the regulator fault supervisor
`timescale 1ns/1ns
module tb_top;
	import regulator_fault_supervisor_pkg::*;
	localparam int OCW = 40;
	localparam int SSD = 20;
	logic clk_sys_i = 1'b0;
	logic arst_n_i = 1'b0;
	pins_s p = '0;
	logic rd = 1'b0;
	logic wr = 1'b0;
	logic [7:0] adr = 8'h00;
	logic [7:0] wd = 8'h00;
	logic [7:0] q;
	logic [PHASES-1:0] pwm;
	logic [PHASES-1:0] oe_n;
	logic [RAILS-1:0] rdy_n;
	logic al_n;
	logic hot_n;
	logic [PHASES-1:0] gate;
	logic [RAILS-1:0] rdy;
	logic al;
	logic hot;
	int n;
	int bad_count = 0;
	int samples_checked = 0;
	always #50 clk_sys_i = ~clk_sys_i;
	regulator_fault_supervisor #(.OC_WAIT_CYCLES(OCW), .SS_DELAY_CYCLES(SSD))
		i_regulator_fault_supervisor (.clk_sys_i(clk_sys_i), .arst_n_i(arst_n_i), .pins_i(p),
		.reg_rd_i(rd), .reg_wr_i(wr), .reg_addr_i(adr), .reg_wdata_i(wd), .reg_rdata_o(q),
		.pwm_o(pwm), .pwm_oe_n_o(oe_n), .rail_ready_oe_n_o(rdy_n), .alert_oe_n_o(al_n),
		.thermal_hot_oe_n_o(hot_n));
	gate_driver_model i_gate_driver_model (.pwm_i(pwm), .pwm_oe_n_i(oe_n), .ready_oe_n_i(rdy_n),
		.alert_oe_n_i(al_n), .hot_oe_n_i(hot_n), .gate_on_o(gate), .ready_o(rdy), .alert_o(al),
		.hot_o(hot));
	task automatic chk(input logic [7:0] s, input logic [7:0] e);
		samples_checked++;
		if (s !== e) begin
			bad_count++;
			$display("mismatch at %0t seen %h expected %h", $time, s, e);
		end
	endtask : chk
	task automatic end_of_test;
		$display("checks %0d mismatches %0d", samples_checked, bad_count);
		if (bad_count == 0 && samples_checked > 0) $display("Finished cleanly");
		else $display("Finished with errors");
		$finish;
	endtask : end_of_test
	task automatic wt(input int c);
		repeat (c) @(negedge clk_sys_i);
	endtask : wt
	task automatic rreg(input logic [7:0] a, input logic [7:0] e);
		adr = a;
		rd = 1'b1;
		wt(1);
		rd = 1'b0;
		chk(q, e);
		wt(1);
	endtask : rreg
	task automatic wreg(input logic [7:0] a, input logic [7:0] d);
		adr = a;
		wd = d;
		wr = 1'b1;
		wt(1);
		wr = 1'b0;
		wt(1);
	endtask : wreg
	// Bounded wait for both ready lines released
	task automatic wrdy;
		n = 0;
		while (rdy !== 2'h3 && n < 1000) begin
			wt(1);
			n++;
		end
		if (n == 1000) begin
			bad_count++;
			end_of_test;
		end
	endtask : wrdy
	task automatic s_regs;
		rreg(8'h15, 8'h00);
		rreg(8'h30, 8'h00);
		rreg(8'h31, 8'h01);
		adr = 8'h15;
		wd = 8'hFF;
		wr = 1'b1;
		wt(1);
		wr = 1'b0;
		rreg(8'h15, 8'h00);
		wreg(8'h30, 8'h01);
		rreg(8'h30, 8'h01);
		wreg(8'h30, 8'h00);
		rreg(8'h30, 8'h00);
	endtask : s_regs
	task automatic s_code;
		p.load_current_monitor_pin_mv = 11'h258;
		wt(SAMPLE_CYC + 4);
		rreg(8'h15, 8'hAA);
		p.load_current_monitor_pin_mv = 11'h384;
		wt(SAMPLE_CYC + 4);
		rreg(8'h15, 8'hFF);
		chk(8'(al), 8'h00);
		p.load_current_monitor_pin_mv = 11'h000;
		wt(SAMPLE_CYC + 4);
		rreg(8'h15, 8'h00);
		chk(8'(al), 8'h01);
	endtask : s_code
	task automatic s_start;
		p.vout_mv = {12'h3E8, 12'h9C4};
		p.por_ok = 1'b1;
		wt(6);
		chk(8'({oe_n[5:0], pwm[0]}), 8'h00);
		chk(8'(hot), 8'h01);
		chk(8'(rdy), 8'h00);
		p.dac_mv = {12'h3E8, 12'h3E8};
		p.vout_mv = {12'h3E8, 12'h3E8};
		p.ss_done = 2'h3;
		p.pwm_req = 7'h7F;
		p.pwr_en = 1'b1;
		p.vtt_en = 1'b1;
		wrdy;
		chk(8'(n >= SSD), 8'h01);
		chk(8'(gate), 8'h7F);
	endtask : s_start
	task automatic s_peak;
		p.peak_over[6] = 1'b1;
		wt(1);
		p.peak_over[6] = 1'b0;
		wt(6);
		chk(8'(gate[6]), 8'h00);
		p.cycle_start[6] = 1'b1;
		wt(1);
		p.cycle_start[6] = 1'b0;
		wt(4);
		chk(8'({gate[6], rdy}), 8'h07);
		p.vid_off = 2'h3;
		wt(6);
		chk(8'(rdy), 8'h02);
		p.vid_off = 2'h0;
		wrdy;
	endtask : s_peak
	task automatic s_oc;
		p.load_current_monitor_pin_mv = 11'h4B0;
		wt(6);
		chk(8'({oe_n[5:0], rdy[0]}), 8'h7E);
		p.load_current_monitor_pin_mv = 11'h000;
		wrdy;
		chk(8'(n > OCW + SSD - 6 && n < OCW + SSD + 10), 8'h01);
		p.avg_over[0] = 1'b1;
		wt(6);
		n = 0;
		repeat (3 * (OCW + SSD)) begin
			wt(1);
			n += rdy[0];
		end
		chk(8'(n), 8'h00);
		p.avg_over[0] = 1'b0;
		wrdy;
	endtask : s_oc
	task automatic s_ov;
		p.vout_mv[0] = 12'h4B0;
		wt(6);
		chk(8'({oe_n[5:0], pwm[0]}), 8'h00);
		chk(8'(rdy[0]), 8'h00);
		p.vout_mv[0] = 12'h41A;
		wt(6);
		chk(8'(oe_n[5:0]), 8'h3F);
		p.vout_mv[0] = 12'h9C4;
		wt(6);
		chk(8'(oe_n[5:0]), 8'h00);
		p.vout_mv[0] = 12'h3E8;
		wt(3 * (OCW + SSD));
		chk(8'(rdy), 8'h02);
		p.pwr_en = 1'b0;
		wt(6);
		p.pwr_en = 1'b1;
		wrdy;
	endtask : s_ov
	task automatic s_hot;
		p.tms_ratio = 14'h3FFF;
		for (int i = 0; i < 7; i++) begin
			p.tlimit = 3'(i);
			p.tm_ratio = HOT_SET[i] - 14'h0001;
			wt(5);
			chk(8'(hot), 8'h00);
			p.tm_ratio = HOT_SET[i] + 14'h0001;
			wt(5);
			chk(8'(hot), 8'h00);
			p.tm_ratio = HOT_CLR[i] + 14'h0001;
			wt(5);
			chk(8'(hot), 8'h01);
		end
		p.tlimit = 3'h7;
		p.tm_ratio = HOT_SET[6] + 14'h0001;
		wt(5);
		chk(8'(hot), 8'h01);
		p.tms_ratio = 14'h0000;
		wt(5);
		chk(8'(hot), 8'h00);
		p.pwr_en = 1'b0;
		wt(6);
		chk(8'(hot), 8'h01);
	endtask : s_hot
	initial begin
		wt(2);
		arst_n_i = 1'b1;
		s_regs;
		s_code;
		s_start;
		s_peak;
		s_oc;
		s_ov;
		s_hot;
		end_of_test;
	end
endmodule : tb_top
